// ==== shared/spams_regs.vh ====
// Register map, field positions, reset values and mode codes
`ifndef SPAMS_REGS_VH
`define SPAMS_REGS_VH

// ----------------------------------------------------------------------
// Register word indices (byte address is the index times 4)
// ----------------------------------------------------------------------
`define SPAMS_IDX_MASK     12'h78e
`define SPAMS_IDX_STATUS   12'h78f
`define SPAMS_IDX_DIVADDR  12'h790
`define SPAMS_IDX_CTRL     12'h791
`define SPAMS_IDX_BUF      12'h792
`define SPAMS_IDX_IRQ_STAT 12'h793
`define SPAMS_IDX_IRQ_MASK 12'h794
`define SPAMS_IDX_MATCH    12'h795
`define SPAMS_AW           14

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPAMS_RST_MASK     8'hff
`define SPAMS_RST_STATUS   8'h00
`define SPAMS_RST_DIVADDR  8'h00
`define SPAMS_RST_CTRL     8'h00
`define SPAMS_RST_IRQ      8'h00

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SPAMS_ST_SMP       7
`define SPAMS_ST_EDGE      6
`define SPAMS_ST_DATA      5
`define SPAMS_ST_STOP      4
`define SPAMS_ST_START     3
`define SPAMS_ST_DIR       2
`define SPAMS_ST_UA        1
`define SPAMS_ST_BF        0

// ----------------------------------------------------------------------
// Control register: enable bit and mode field
// ----------------------------------------------------------------------
`define SPAMS_CTRL_EN      4
`define SPAMS_MODE_I2C_C7  4'h6
`define SPAMS_MODE_I2C_C10 4'h7
`define SPAMS_MODE_I2C_H   4'h8
`define SPAMS_MODE_SPI_H   4'ha
`define SPAMS_MODE_C7_SP   4'he
`define SPAMS_MODE_C10_SP  4'hf

// ----------------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------------
`define SPAMS_EV_START     0
`define SPAMS_EV_STOP      1
`define SPAMS_EV_MATCH     2
`define SPAMS_EV_DONE      3
`define SPAMS_EV_UA        4

// ----------------------------------------------------------------------
// Divider arithmetic: period = (n+1) * 4 oscillator cycles
// ----------------------------------------------------------------------
`define SPAMS_OSC_PER_TICK 4
`define SPAMS_HALF_TICKS   2

`endif

// ==== hw/spams_baud_gen.v ====
// Baud generator: reload down counter producing serial clock half periods
`timescale 1ns/10ps
`include "spams_regs.vh"

module spams_baud_gen #(
  parameter CW = 10
) (
  // Clock and reset
  hclk,
  hresetn,
  // Control
  start,
  stop,
  divider,
  // Output
  half_tick,
  running
);
  input  wire         hclk;
  input  wire         hresetn;
  input  wire         start;
  input  wire         stop;
  input  wire [7:0]   divider;
  output wire         half_tick;
  output reg          running;

  // Half period = (n+1)*2 clocks, two reloads per serial clock period
  localparam [CW-1:0] HALF = `SPAMS_HALF_TICKS;
  wire [CW-1:0] reload;
  reg  [CW-1:0] cnt_ff;
  // Sized factor keeps the product at counter width
  assign reload = ({{(CW-8){1'b0}}, divider} + {{(CW-1){1'b0}}, 1'b1})
                  * HALF - {{(CW-1){1'b0}}, 1'b1};
  assign half_tick = running && (cnt_ff == {CW{1'b0}});

  // Down counter, auto reload while running
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= {CW{1'b0}};
      running <= 1'b0;
    end else if (start) begin
      cnt_ff  <= reload;
      running <= 1'b1;
    end else if (stop) begin
      running <= 1'b0;
    end else if (running) begin
      if (cnt_ff == {CW{1'b0}})
        cnt_ff <= reload;
      else
        cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // spams_baud_gen

// ==== hw/spams_core.v ====
// Address, mask and status registers of the serial port over AHB-Lite
`timescale 1ns/10ps
`include "spams_regs.vh"

module spams_core (
  // AHB-Lite clock and reset
  hclk,
  hresetn,
  // AHB-Lite slave
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hrdata,
  hresp,
  // Bus engine status inputs (asynchronous to hclk)
  cond_start,
  cond_stop,
  byte_done,
  byte_is_data,
  client_read,
  recv_addr,
  recv_is_high,
  xfer_done,
  // Option, address match, baud and interrupt outputs
  spi_sample_end,
  spi_launch_idle,
  i2c_slew_off,
  i2c_smbus_in,
  addr_match,
  baud_half_tick,
  baud_running,
  irq
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output wire        hreadyout;
  output reg  [31:0] hrdata;
  output wire        hresp;
  input  wire        cond_start;
  input  wire        cond_stop;
  input  wire        byte_done;
  input  wire        byte_is_data;
  input  wire        client_read;
  input  wire [7:0]  recv_addr;
  input  wire        recv_is_high;
  input  wire        xfer_done;
  output reg         spi_sample_end;
  output reg         spi_launch_idle;
  output reg         i2c_slew_off;
  output reg         i2c_smbus_in;
  output reg         addr_match;
  output wire        baud_half_tick;
  output wire        baud_running;
  output wire        irq;

  // --------------------------------------------------------------------
  // Input synchronisers (two flops before any use)
  // --------------------------------------------------------------------
  localparam NS = 15;
  wire [NS-1:0] async_in;
  reg  [NS-1:0] sync1_ff;
  reg  [NS-1:0] sync2_ff;
  reg  [4:0]    prev_ff;
  assign async_in = {recv_addr, recv_is_high, client_read, byte_is_data,
                     xfer_done, byte_done, cond_stop, cond_start};

  // Two stage synchroniser, then a copy for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= {NS{1'b0}};
      sync2_ff <= {NS{1'b0}};
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[4:0];
    end
  end

  wire       s_start  = sync2_ff[0];
  wire       s_stop   = sync2_ff[1];
  wire       s_byte   = sync2_ff[2];
  wire       s_xdone  = sync2_ff[3];
  wire       s_isdata = sync2_ff[4];
  wire       s_rd     = sync2_ff[5];
  wire       s_high   = sync2_ff[6];
  wire [7:0] s_addr   = sync2_ff[14:7];
  wire       ev_start = s_start & ~prev_ff[0];
  wire       ev_stop  = s_stop & ~prev_ff[1];
  wire       ev_byte  = s_byte & ~prev_ff[2];
  wire       ev_xdone = s_xdone & ~prev_ff[3];

  // --------------------------------------------------------------------
  // AHB-Lite address phase capture
  // --------------------------------------------------------------------
  reg                 wr_ff;
  reg                 rd_ff;
  reg [`SPAMS_AW-1:0] addr_ff;
  wire                take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register request for its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
      addr_ff <= {`SPAMS_AW{1'b0}};
    end else begin
      wr_ff   <= take & hwrite;
      rd_ff   <= take & ~hwrite;
      addr_ff <= haddr[`SPAMS_AW-1:0];
    end
  end

  wire [11:0] widx = addr_ff[`SPAMS_AW-1:2];
  wire        w_mask  = wr_ff && widx == `SPAMS_IDX_MASK;
  wire        w_stat  = wr_ff && widx == `SPAMS_IDX_STATUS;
  wire        w_div   = wr_ff && widx == `SPAMS_IDX_DIVADDR;
  wire        w_ctrl  = wr_ff && widx == `SPAMS_IDX_CTRL;
  wire        w_buf   = wr_ff && widx == `SPAMS_IDX_BUF;
  wire        w_istat = wr_ff && widx == `SPAMS_IDX_IRQ_STAT;
  wire        w_imask = wr_ff && widx == `SPAMS_IDX_IRQ_MASK;

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [7:0] mask_ff;
  reg [7:0] div_ff;
  reg [4:0] ctrl_ff;
  reg [7:0] buf_ff;
  reg [1:0] opt_ff;
  reg [4:0] imask_ff;

  // Writable fields; read-only status flags never take bus data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff  <= `SPAMS_RST_MASK;
      div_ff   <= `SPAMS_RST_DIVADDR;
      ctrl_ff  <= 5'h00;
      buf_ff   <= 8'h00;
      opt_ff   <= 2'h0;
      imask_ff <= 5'h00;
    end else begin
      if (w_mask)  mask_ff  <= hwdata[7:0];
      if (w_div)   div_ff   <= hwdata[7:0];
      if (w_ctrl)  ctrl_ff  <= hwdata[4:0];
      if (w_buf)   buf_ff   <= hwdata[7:0];
      if (w_stat)  opt_ff   <= hwdata[7:6];
      if (w_imask) imask_ff <= hwdata[4:0];
    end
  end

  wire [3:0] mode   = ctrl_ff[3:0];
  wire       en     = ctrl_ff[`SPAMS_CTRL_EN];
  wire       m_c10  = mode == `SPAMS_MODE_I2C_C10 ||
                      mode == `SPAMS_MODE_C10_SP;
  wire       m_c7   = mode == `SPAMS_MODE_I2C_C7 ||
                      mode == `SPAMS_MODE_C7_SP;
  wire       m_ih   = mode == `SPAMS_MODE_I2C_H;
  wire       m_spi  = mode[3] == 1'b0 && !m_c10 && !m_c7 ||
                      mode == `SPAMS_MODE_SPI_H;
  wire       m_i2c  = !m_spi;
  wire       m_host = m_ih || mode == `SPAMS_MODE_SPI_H ||
                      mode[3:2] == 2'b00;

  // --------------------------------------------------------------------
  // Option decode for the bus engines
  // --------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spi_sample_end  <= 1'b0;
      spi_launch_idle <= 1'b0;
      i2c_slew_off    <= 1'b0;
      i2c_smbus_in    <= 1'b0;
    end else begin
      spi_sample_end  <= m_spi & m_host & opt_ff[1];
      i2c_slew_off    <= m_i2c & opt_ff[1];
      spi_launch_idle <= m_spi & opt_ff[0];
      i2c_smbus_in    <= m_i2c & opt_ff[0];
    end
  end

  // --------------------------------------------------------------------
  // Address match with mask
  // --------------------------------------------------------------------
  reg [7:0] cmp_en;
  reg [7:0] own;
  always @* begin
    cmp_en = {mask_ff[7:1], m_c10 & mask_ff[0]};
    own    = div_ff;
    if (m_c7) begin
      own       = {div_ff[7:1], 1'b0};
      cmp_en[0] = 1'b0;
    end else if (m_c10 && s_high) begin
      own    = {5'h1e, div_ff[2:1], 1'b0};
      cmp_en = {5'h1f, mask_ff[2:1], 1'b0};
    end
  end

  wire match_now = ((s_addr ^ own) & cmp_en) == 8'h00;
  // One-cycle pulse on a matched address byte in 10-bit client mode
  wire ua_set    = ev_byte && m_c10 && !s_isdata && match_now;

  // --------------------------------------------------------------------
  // Status flags set by hardware
  // --------------------------------------------------------------------
  reg st_data_ff;
  reg st_stop_ff;
  reg st_start_ff;
  reg st_dir_ff;
  reg st_ua_ff;
  reg st_bf_ff;
  reg host_busy_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_data_ff   <= 1'b0;
      st_stop_ff   <= 1'b0;
      st_start_ff  <= 1'b0;
      st_dir_ff    <= 1'b0;
      st_ua_ff     <= 1'b0;
      st_bf_ff     <= 1'b0;
      host_busy_ff <= 1'b0;
      addr_match   <= 1'b0;
    end else begin
      // Last condition seen
      if (ev_start && m_i2c) begin
        st_start_ff <= 1'b1;
        st_stop_ff  <= 1'b0;
      end else if (ev_stop && m_i2c) begin
        st_stop_ff  <= 1'b1;
        st_start_ff <= 1'b0;
      end
      // Host transmission tracking
      if (w_buf)
        host_busy_ff <= 1'b1;
      else if (ev_xdone)
        host_busy_ff <= 1'b0;
      // Client byte bookkeeping
      if (ev_byte && !m_host) begin
        st_data_ff <= s_isdata;
        if (!s_isdata) begin
          addr_match <= match_now;
          if (match_now)
            st_dir_ff <= s_rd;
        end
      end
      if (m_ih)
        st_dir_ff <= host_busy_ff;
      // Update address in 10-bit client; cleared by new divider write
      if (ua_set)
        st_ua_ff <= 1'b1;
      else if (w_div || !m_c10)
        st_ua_ff <= 1'b0;
      if (ev_byte)
        st_bf_ff <= 1'b1;
      else if (w_buf || rd_ff && widx == `SPAMS_IDX_BUF)
        st_bf_ff <= 1'b0;
      if (!en) begin
        st_bf_ff <= 1'b0;
      end
    end
  end

  wire [7:0] status = {opt_ff, st_data_ff, st_stop_ff, st_start_ff,
                       st_dir_ff, st_ua_ff, st_bf_ff};

  // --------------------------------------------------------------------
  // Baud generator, started by a buffer write in host modes
  // --------------------------------------------------------------------
  spams_baud_gen #(
    .CW (10)
  ) u_baud (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .start     (w_buf & m_host & en),
    .stop      (ev_xdone | ~en),
    .divider   (div_ff),
    .half_tick (baud_half_tick),
    .running   (baud_running)
  );

  // --------------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // --------------------------------------------------------------------
  reg  [4:0] istat_ff;
  wire [4:0] ev_vec = {ua_set, ev_xdone, ev_byte & match_now,
                       ev_stop, ev_start};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      istat_ff <= 5'h00;
    else
      istat_ff <= (istat_ff & ~({5{w_istat}} & hwdata[4:0])) | ev_vec;
  end
  assign irq = |(istat_ff & imask_ff);

  // --------------------------------------------------------------------
  // Read data, unmapped addresses read zero
  // --------------------------------------------------------------------
  wire [11:0] ridx = haddr[`SPAMS_AW-1:2];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (take && !hwrite) begin
      case (ridx)
        `SPAMS_IDX_MASK:     hrdata <= {24'h000000, mask_ff};
        `SPAMS_IDX_STATUS:   hrdata <= {24'h000000, status};
        `SPAMS_IDX_DIVADDR:  hrdata <= {24'h000000, div_ff};
        `SPAMS_IDX_CTRL:     hrdata <= {27'h0000000, ctrl_ff};
        `SPAMS_IDX_BUF:      hrdata <= {24'h000000, buf_ff};
        `SPAMS_IDX_IRQ_STAT: hrdata <= {27'h0000000, istat_ff};
        `SPAMS_IDX_IRQ_MASK: hrdata <= {27'h0000000, imask_ff};
        `SPAMS_IDX_MATCH:    hrdata <= {31'h00000000, addr_match};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // spams_core

// ==== tb/spams_chk_sva.sv ====
// Port-level timing checker for the serial port register block
`timescale 1ns/10ps
`include "spams_regs.vh"
module spams_chk (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        hresp,
  // Engine events and outputs
  input wire        cond_start,
  input wire        cond_stop,
  input wire        byte_done,
  input wire        xfer_done,
  input wire        addr_match,
  input wire        baud_half_tick,
  input wire        baud_running,
  input wire        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic        ap;
  logic        wdp_ff;
  logic        seen_ff;
  logic [11:0] idx_ff;
  logic [7:0]  div_ff;
  logic [9:0]  gap_ff;
  logic [3:0]  swr_ff;
  logic [3:0]  sbuf_ff;
  logic [3:0]  sev_ff;
  logic [3:0]  sbd_ff;
  assign ap = hsel & hready & htrans[1];
  // Shadow divider, tick spacing and cycles since causes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdp_ff <= 1'b0;
      seen_ff <= 1'b0;
      idx_ff <= 12'h0;
      div_ff <= 8'h0;
      gap_ff <= 10'h0;
      swr_ff <= 4'hf;
      sbuf_ff <= 4'hf;
      sev_ff <= 4'hf;
      sbd_ff <= 4'hf;
    end else begin
      wdp_ff <= ap & hwrite;
      if (ap) idx_ff <= haddr[13:2];
      if (wdp_ff && idx_ff == `SPAMS_IDX_DIVADDR) div_ff <= hwdata[7:0];
      gap_ff <= baud_half_tick ? 10'h1 : gap_ff + {9'h0, ~&gap_ff};
      seen_ff <= baud_running & (seen_ff | baud_half_tick);
      swr_ff <= wdp_ff ? 4'h0 : swr_ff + {3'h0, ~&swr_ff};
      sbuf_ff <= (wdp_ff && idx_ff == `SPAMS_IDX_BUF) ? 4'h0 :
                 sbuf_ff + {3'h0, ~&sbuf_ff};
      sev_ff <= (cond_start | cond_stop | byte_done | xfer_done) ? 4'h0 :
                sev_ff + {3'h0, ~&sev_ff};
      sbd_ff <= byte_done ? 4'h0 : sbd_ff + {3'h0, ~&sbd_ff};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_steady_tick;
    seen_ff && baud_half_tick;
  endsequence
  sequence s_no_read;
    !(ap && !hwrite);
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_tick_gap: assert property (s_steady_tick |->
    gap_ff == ({2'h0, div_ff} + 10'h1) * 10'h2)
    else $error("half tick spacing wrong");
  chk_tick_running: assert property (baud_half_tick |-> baud_running)
    else $error("half tick while idle");
  chk_run_start: assert property ($rose(baud_running) |-> sbuf_ff <= 4'h4)
    else $error("baud start without buffer write");
  chk_run_stop: assert property (
    $rose(xfer_done) && baud_running |-> ##[1:8] !baud_running)
    else $error("baud did not stop");
  chk_rdata_hold: assert property (s_no_read |=> $stable(hrdata))
    else $error("read data moved without read");
  chk_irq_fall: assert property ($fell(irq) |-> swr_ff <= 4'h3)
    else $error("irq fell without write");
  chk_irq_rise: assert property (
    $rose(irq) |-> sev_ff <= 4'h6 || swr_ff <= 4'h3)
    else $error("irq rose without cause");
  chk_match_cause: assert property ($changed(addr_match) |->
    sbd_ff <= 4'h6 || swr_ff <= 4'h3)
    else $error("match changed without byte");
endmodule // spams_chk

bind spams_core spams_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cond_start,
  .cond_stop, .byte_done, .xfer_done, .addr_match, .baud_half_tick,
  .baud_running, .irq);

// ==== tb/spams_bus_model.sv ====
// Behavioural bus engine feeding condition and byte events
`timescale 1ns/10ps
module spams_bus_model (
  // Clock
  input  wire        hclk,
  // Events
  output logic       cond_start,
  output logic       cond_stop,
  output logic       byte_done,
  output logic       xfer_done,
  // Byte qualifiers
  output logic       byte_is_data,
  output logic       client_read,
  output logic       recv_is_high,
  output logic [7:0] recv_addr
);
  // Idle engine at time zero
  initial begin
    cond_start = 1'b0;
    cond_stop = 1'b0;
    byte_done = 1'b0;
    xfer_done = 1'b0;
    byte_is_data = 1'b0;
    client_read = 1'b0;
    recv_is_high = 1'b0;
    recv_addr = 8'h00;
  end
  task automatic hold(input int len);
    repeat (len) @(posedge hclk);
  endtask
  // Start (0), stop (1) or transfer done (2) as a held level
  task automatic event_pulse(input int sel);
    @(posedge hclk);
    case (sel)
      0: cond_start <= 1'b1;
      1: cond_stop <= 1'b1;
      default: xfer_done <= 1'b1;
    endcase
    hold(4);
    cond_start <= 1'b0;
    cond_stop <= 1'b0;
    xfer_done <= 1'b0;
    hold(4);
  endtask
  // One byte with its qualifiers, which go stale after release
  task automatic send_byte(input [7:0] a, input dat, rw, hi);
    @(posedge hclk);
    recv_addr <= a;
    byte_is_data <= dat;
    client_read <= rw;
    recv_is_high <= hi;
    byte_done <= 1'b1;
    hold(6);
    byte_done <= 1'b0;
    hold(2);
    recv_addr <= ~a;
    byte_is_data <= ~dat;
    client_read <= ~rw;
    recv_is_high <= ~hi;
    hold(4);
  endtask
endmodule // spams_bus_model

// ==== tb/tb_serial_port_addr_match_status.sv ====
// Self-checking bench for the serial port address, mask and status block
`timescale 1ns/10ps
`include "spams_regs.vh"
module tb_serial_port_addr_match_status;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic        dir_exp = 1'b0;
  wire         hreadyout, hresp, cond_start, cond_stop, byte_done, irq;
  wire         byte_is_data, client_read, recv_is_high, xfer_done;
  wire         spi_sample_end, spi_launch_idle, i2c_slew_off, i2c_smbus_in;
  wire         addr_match, baud_half_tick, baud_running;
  wire [31:0]  hrdata;
  wire [7:0]   recv_addr;
  int          mismatches = 0;
  int          compares = 0;
  int          n;
  always #10 hclk = ~hclk;
  spams_core u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cond_start,
    .cond_stop, .byte_done, .byte_is_data, .client_read, .recv_addr,
    .recv_is_high, .xfer_done, .spi_sample_end, .spi_launch_idle,
    .i2c_slew_off, .i2c_smbus_in, .addr_match, .baud_half_tick,
    .baud_running, .irq);
  spams_bus_model u_bus (.hclk, .cond_start, .cond_stop, .byte_done,
    .byte_is_data, .client_read, .recv_addr, .recv_is_high, .xfer_done);
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single-word transfer: address phase, then data phase
  task automatic xfer(input [11:0] idx, input w, input [31:0] wd);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input [11:0] idx, input [31:0] d);
    xfer(idx, 1'b1, d);
  endtask
  task automatic rchk(input [11:0] idx, input [31:0] m, exp, input string s);
    xfer(idx, 1'b0, 32'h0);
    chk(rd & m, exp, s);
  endtask
  // Set mode, own address and mask, send one address byte
  task automatic acase(input [7:0] ctl, dv, msk, rx, input hi, rw, exp);
    wr(`SPAMS_IDX_CTRL, {24'h0, ctl});
    wr(`SPAMS_IDX_DIVADDR, {24'h0, dv});
    wr(`SPAMS_IDX_MASK, {24'h0, msk});
    u_bus.send_byte(rx, 1'b0, rw, hi);
    chk({31'h0, addr_match}, {31'h0, exp}, "addr_match");
    // Direction only follows a matched address byte
    if (exp) dir_exp = rw;
    rchk(`SPAMS_IDX_STATUS, 32'h24, {29'h0, dir_exp, 2'h0}, "dir");
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`SPAMS_IDX_MASK, 32'hff, 32'hff, "mask reset");
    rchk(`SPAMS_IDX_STATUS, 32'hff, 32'h0, "status reset");
    rchk(`SPAMS_IDX_DIVADDR, 32'hff, 32'h0, "divider reset");
    wr(`SPAMS_IDX_STATUS, 32'hff);
    rchk(`SPAMS_IDX_STATUS, 32'hffffffff, 32'hc0, "status wr");
    wr(12'h7a0, 32'h5a);
    rchk(12'h7a0, 32'hffffffff, 32'h0, "unmapped");
    // Option outputs for every value of the two option bits
    for (n = 0; n < 4; n++) begin
      wr(`SPAMS_IDX_CTRL, 32'h18);
      wr(`SPAMS_IDX_STATUS, {24'h0, n[1:0], 6'h0});
      repeat (2) @(posedge hclk);
      chk({30'h0, i2c_slew_off, i2c_smbus_in}, n, "i2c opt");
      wr(`SPAMS_IDX_CTRL, 32'h1a);
      repeat (2) @(posedge hclk);
      chk({30'h0, spi_sample_end, spi_launch_idle}, n, "spi opt");
    end
    // Host transfer with divider 3: half period of 8 clocks
    wr(`SPAMS_IDX_DIVADDR, 32'h3);
    rchk(`SPAMS_IDX_DIVADDR, 32'hff, 32'h3, "divider");
    wr(`SPAMS_IDX_CTRL, 32'h18);
    wr(`SPAMS_IDX_BUF, 32'h55);
    while (baud_half_tick !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    n = 1;
    while (baud_half_tick !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    chk(n, (3 + 1) * 2, "half period");
    chk({31'h0, baud_running}, 32'h1, "baud run");
    rchk(`SPAMS_IDX_STATUS, 32'h04, 32'h04, "host busy");
    u_bus.event_pulse(2);
    chk({31'h0, baud_running}, 32'h0, "baud stop");
    rchk(`SPAMS_IDX_STATUS, 32'h04, 32'h0, "host idle");
    // Client address matching in every client mode
    wr(`SPAMS_IDX_STATUS, 32'h0);
    acase(8'h16, 8'ha4, 8'hff, 8'ha5, 1'b0, 1'b1, 1'b1);
    acase(8'h16, 8'ha4, 8'hff, 8'ha6, 1'b0, 1'b0, 1'b0);
    acase(8'h16, 8'ha4, 8'hfd, 8'ha6, 1'b0, 1'b1, 1'b1);
    acase(8'h1e, 8'ha4, 8'h7f, 8'h25, 1'b0, 1'b0, 1'b1);
    acase(8'h16, 8'ha4, 8'hfe, 8'ha5, 1'b0, 1'b0, 1'b1);
    acase(8'h17, 8'h06, 8'hff, 8'hf6, 1'b1, 1'b0, 1'b1);
    rchk(`SPAMS_IDX_STATUS, 32'h02, 32'h02, "update due");
    wr(`SPAMS_IDX_DIVADDR, 32'h3c);
    rchk(`SPAMS_IDX_STATUS, 32'h02, 32'h0, "update done");
    acase(8'h1f, 8'hf8, 8'hff, 8'hf2, 1'b1, 1'b1, 1'b0);
    acase(8'h17, 8'h3c, 8'hff, 8'h3c, 1'b0, 1'b0, 1'b1);
    acase(8'h17, 8'h3c, 8'hff, 8'h3d, 1'b0, 1'b0, 1'b0);
    acase(8'h17, 8'h3c, 8'hfe, 8'h3d, 1'b0, 1'b1, 1'b1);
    u_bus.send_byte(8'h77, 1'b1, 1'b0, 1'b0);
    rchk(`SPAMS_IDX_STATUS, 32'h20, 32'h20, "data flag");
    // Conditions, interrupt mask and clear
    wr(`SPAMS_IDX_IRQ_STAT, 32'h1f);
    wr(`SPAMS_IDX_IRQ_MASK, 32'h01);
    u_bus.event_pulse(1);
    rchk(`SPAMS_IDX_STATUS, 32'h18, 32'h10, "stop seen");
    chk({31'h0, irq}, 32'h0, "irq masked");
    u_bus.event_pulse(0);
    rchk(`SPAMS_IDX_STATUS, 32'h18, 32'h08, "start seen");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rchk(`SPAMS_IDX_IRQ_STAT, 32'h03, 32'h03, "irq status");
    wr(`SPAMS_IDX_IRQ_STAT, 32'h01);
    rchk(`SPAMS_IDX_IRQ_STAT, 32'h03, 32'h02, "irq clear");
    chk({31'h0, irq}, 32'h0, "irq low");
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    report_and_stop;
  end
endmodule // tb_serial_port_addr_match_status
